// File: src/ptl_defs.svh
// timing constants for the transceiver mac-side timing block
`ifndef PTL_DEFS_SVH
`define PTL_DEFS_SVH

// system clock period
`define PTL_SYS_NS          4
// bit times at each line rate
`define PTL_BIT100_NS       10
`define PTL_BIT10_NS        100
// transmit latency in bit times (10 Mb/s figure in tenths of a bit)
`define PTL_TX_LAT100_BITS  6
`define PTL_TX_LAT10_TENTHS 35
// receive latencies in bit times at 100 Mb/s
`define PTL_CRS_ON_BITS     20
`define PTL_RX_LAT_BITS     24
`define PTL_CRS_OFF_BITS    24
// end-of-packet high time
`define PTL_EOP_MIN_NS      250
`define PTL_EOP_TYP_NS      300
// clock phases
`define PTL_MII100_HALF_NS  20
`define PTL_MII10_HALF_NS   200
`define PTL_SER_TXH_NS      25
`define PTL_SER_TXL_NS      75
`define PTL_SER_RX_NS       50

// derived cycle counts
`define PTL_TX_LAT100_CYC \
  ((`PTL_TX_LAT100_BITS * `PTL_BIT100_NS) / `PTL_SYS_NS)
`define PTL_TX_LAT10_CYC \
  ((`PTL_TX_LAT10_TENTHS * `PTL_BIT10_NS) / (10 * `PTL_SYS_NS))
`define PTL_CRS_ON_CYC  ((`PTL_CRS_ON_BITS * `PTL_BIT100_NS) / `PTL_SYS_NS)
`define PTL_RX_LAT_CYC  ((`PTL_RX_LAT_BITS * `PTL_BIT100_NS) / `PTL_SYS_NS)
`define PTL_CRS_OFF_CYC ((`PTL_CRS_OFF_BITS * `PTL_BIT100_NS) / `PTL_SYS_NS)
`define PTL_EOP_CYC     (`PTL_EOP_TYP_NS / `PTL_SYS_NS)
`define PTL_EOP_MIN_CYC ((`PTL_EOP_MIN_NS + `PTL_SYS_NS - 1) / `PTL_SYS_NS)
`define PTL_MII100_HALF_CYC (`PTL_MII100_HALF_NS / `PTL_SYS_NS)
`define PTL_MII10_HALF_CYC  (`PTL_MII10_HALF_NS / `PTL_SYS_NS)
`define PTL_SER_TXH_CYC     (`PTL_SER_TXH_NS / `PTL_SYS_NS)
`define PTL_SER_TXL_CYC \
  ((`PTL_SER_TXH_NS + `PTL_SER_TXL_NS) / `PTL_SYS_NS - `PTL_SER_TXH_CYC)
`define PTL_SER_RXH_CYC     (`PTL_SER_RX_NS / `PTL_SYS_NS)
`define PTL_SER_RXL_CYC \
  ((2 * `PTL_SER_RX_NS) / `PTL_SYS_NS - `PTL_SER_RXH_CYC)

// delay line address width
`define PTL_DLY_AW 7

`endif

// File: src/ptl_pkg.sv
// types shared by the transceiver mac-side timing block
package ptl_pkg;

  // interface mode
  typedef enum logic [1:0] {
    PTL_MII100,
    PTL_MII10,
    PTL_SER10
  } ptl_mode_e;

  // a nibble with its qualifier (enable, valid or line activity)
  typedef struct packed {
    logic       en;
    logic [3:0] data;
  } ptl_nib_s;

endpackage : ptl_pkg

// File: src/ptl_dly_mem.sv
// delay-line memory with registered read data
`timescale 1ns/1ps
module ptl_dly_mem #(
  parameter int W  = 5,
  parameter int AW = 7
) (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [W-1:0]  wr_data_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [W-1:0]  rd_data_out
);

  // storage cleared at reset so the line never shows unknown data
  logic [W-1:0] mem [0:(1<<AW)-1];

  // write every cycle, read one cycle late through a register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < (1 << AW); i++) begin
        mem[i] <= '0;
      end
      rd_data_out <= '0;
    end else begin
      mem[wr_addr_in] <= wr_data_in;
      rd_data_out     <= mem[rd_addr_in];
    end
  end

endmodule : ptl_dly_mem

// File: src/ptl_timing.sv
// mac-side clocking and latency engine of a 10/100 transceiver
// Overview of operation
// - 100M: J starts 6 bits after edge
// - 100M: T starts 6 bits after edge
// - 100M bit time is 10 ns
// - 10M bit time is 100 ns
// - 100M: carrier 20 bits, data 24 bits
// - 100M: carrier drops 24 bits after T
// - 10M MII samples on falling clock
// - clock stretch allowed, never short phase
// - 10M line output 3.5 bits after edge
// - end-of-packet high at least 250 ns
// - serial tx clock 25/75, rising sample
// - serial rx clock 50/50, falling update
`timescale 1ns/1ps
`include "ptl_defs.svh"
module ptl_timing (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic [1:0]       mode_in,
  input  wire ptl_pkg::ptl_nib_s mac_tx_in,
  input  wire ptl_pkg::ptl_nib_s line_rx_in,
  input  wire logic             line_lock_in,
  output logic                  tx_clk_out,
  output logic                  rx_clk_out,
  output ptl_pkg::ptl_nib_s     mac_rx_out,
  output logic                  crs_out,
  output ptl_pkg::ptl_nib_s     line_tx_out,
  output logic                  line_sos_out,
  output logic                  line_eos_out,
  output logic                  line_eop_out
);

  localparam int AW = `PTL_DLY_AW;

  // phase length of a generated clock for the given mode and level
  function automatic logic [7:0] half_len(input ptl_pkg::ptl_mode_e m,
                                          input logic lvl,
                                          input logic rx);
    case (m)
      ptl_pkg::PTL_MII100: half_len = 8'(`PTL_MII100_HALF_CYC);
      ptl_pkg::PTL_MII10:  half_len = 8'(`PTL_MII10_HALF_CYC);
      ptl_pkg::PTL_SER10: begin
        if (rx) begin
          half_len = lvl ? 8'(`PTL_SER_RXH_CYC) : 8'(`PTL_SER_RXL_CYC);
        end else begin
          half_len = lvl ? 8'(`PTL_SER_TXH_CYC) : 8'(`PTL_SER_TXL_CYC);
        end
      end
      default:             half_len = 8'(`PTL_MII100_HALF_CYC);
    endcase
  endfunction : half_len

  // pin synchronisers: every outside input passes two flops
  logic [12:0] sync1;                 // first stage, read only by sync2
  logic [12:0] sync2;                 // second stage, safe to use
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= 13'h0000;
      sync2 <= 13'h0000;
    end else begin
      sync1 <= {mode_in, mac_tx_in, line_rx_in, line_lock_in};
      sync2 <= sync1;
    end
  end

  ptl_pkg::ptl_mode_e mode;           // decoded interface mode
  ptl_pkg::ptl_nib_s  mac_tx_q;       // synchronised mac transmit
  ptl_pkg::ptl_nib_s  line_q;         // synchronised line receive
  logic               lock_q;         // synchronised recovered-clock lock
  logic               m100;           // 100 Mb/s mode
  always_comb begin
    case (sync2[12:11])
      2'h1:    mode = ptl_pkg::PTL_MII10;
      2'h2:    mode = ptl_pkg::PTL_SER10;
      default: mode = ptl_pkg::PTL_MII100;  // unused code acts as 100M
    endcase
    mac_tx_q = sync2[10:6];
    line_q   = sync2[5:1];
    lock_q   = sync2[0];
    m100     = (mode == ptl_pkg::PTL_MII100);
  end

  // ---------------- clock generators ----------------
  logic [7:0] tx_cnt, next_tx_cnt;    // transmit phase counter
  logic       tx_clk, next_tx_clk;    // transmit clock level
  logic [7:0] rx_cnt, next_rx_cnt;    // receive phase counter
  logic       rx_clk, next_rx_clk;    // receive clock level
  logic       lock_d, next_lock_d;    // lock seen last cycle
  logic       tx_tog, rx_tog;         // phase ends this cycle
  logic       tx_smp;                 // transmit sampling edge
  logic       rx_upd;                 // receive update edge

  // phases end on the count for the current mode; a source switch
  // restarts the running rx phase, so it only ever grows longer
  always_comb begin
    next_tx_cnt = tx_cnt + 8'h01;
    next_tx_clk = tx_clk;
    tx_tog = (tx_cnt >= half_len(mode, tx_clk, 1'b0) - 8'h01);
    if (tx_tog) begin
      next_tx_clk = !tx_clk;
      next_tx_cnt = 8'h00;
    end
    next_rx_cnt = rx_cnt + 8'h01;
    next_rx_clk = rx_clk;
    next_lock_d = lock_q;
    rx_tog = (rx_cnt >= half_len(mode, rx_clk, 1'b1) - 8'h01);
    if (lock_q != lock_d) begin
      // reference/recovered switch: stretch, never cut short
      rx_tog      = 1'b0;
      next_rx_cnt = 8'h00;
    end else if (rx_tog) begin
      next_rx_clk = !rx_clk;
      next_rx_cnt = 8'h00;
    end
    // 10M MII samples on the fall, other modes on the rise
    tx_smp = tx_tog && ((mode == ptl_pkg::PTL_MII10) ? tx_clk
                                                     : !tx_clk);
    // 100M updates on the rise, 10M modes on the fall
    rx_upd = rx_tog && (m100 ? !rx_clk : rx_clk);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_cnt <= 8'h00;
      tx_clk <= 1'b0;
      rx_cnt <= 8'h00;
      rx_clk <= 1'b0;
      lock_d <= 1'b0;
    end else begin
      tx_cnt <= next_tx_cnt;
      tx_clk <= next_tx_clk;
      rx_cnt <= next_rx_cnt;
      rx_clk <= next_rx_clk;
      lock_d <= next_lock_d;
    end
  end

  assign tx_clk_out = tx_clk;
  assign rx_clk_out = rx_clk;

  // ---------------- transmit path ----------------
  ptl_pkg::ptl_nib_s tx_cap, next_tx_cap;  // value taken at sample edge
  logic [AW-1:0]     wr_ptr, next_wr_ptr;  // shared delay-line pointer
  logic [AW-1:0]     tx_rd, rx_rd;         // delay-line read addresses
  logic              ln_en_d, next_ln_en_d;// line enable last cycle
  logic [7:0]        eop_cnt, next_eop_cnt;// end-of-packet hold counter
  logic              eop, next_eop;        // end-of-packet level
  logic              ln_fall;              // line activity ended

  // the mac changes data on our rising edge (falling edge in serial mode);
  // by the sample edge the synchronised copy has long settled
  always_comb begin
    next_tx_cap = tx_cap;
    if (tx_smp) begin
      next_tx_cap.en = mac_tx_q.en;
      next_tx_cap.data = (mode == ptl_pkg::PTL_SER10) ?
                         {3'h0, mac_tx_q.data[0]} : mac_tx_q.data;
    end
    next_wr_ptr = wr_ptr + AW'(1);
    // read address trails by latency-1; the read register adds one
    if (m100) begin
      tx_rd = wr_ptr - AW'(`PTL_TX_LAT100_CYC - 1);
    end else begin
      tx_rd = wr_ptr - AW'(`PTL_TX_LAT10_CYC - 1);
    end
    rx_rd = wr_ptr - AW'(`PTL_RX_LAT_CYC - 1);
    next_ln_en_d = line_tx_out.en;
    ln_fall = ln_en_d && !line_tx_out.en;
    // 10M: after the last bit, hold the idle-high level
    if (ln_fall && !m100) begin
      next_eop_cnt = 8'(`PTL_EOP_CYC);
    end else if (line_tx_out.en) begin
      next_eop_cnt = 8'h00;
    end else if (eop_cnt != 8'h00) begin
      next_eop_cnt = eop_cnt - 8'h01;
    end else begin
      next_eop_cnt = 8'h00;
    end
    next_eop = (next_eop_cnt != 8'h00);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_cap  <= '0;
      wr_ptr  <= '0;
      ln_en_d <= 1'b0;
      eop_cnt <= 8'h00;
      eop     <= 1'b0;
    end else begin
      tx_cap  <= next_tx_cap;
      wr_ptr  <= next_wr_ptr;
      ln_en_d <= next_ln_en_d;
      eop_cnt <= next_eop_cnt;
      eop     <= next_eop;
    end
  end

  // transmit latency line: the line output is the read register
  ptl_dly_mem #(.W(5), .AW(AW)) u_tx_dly (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .wr_addr_in  (wr_ptr),
    .wr_data_in  (tx_cap),
    .rd_addr_in  (tx_rd),
    .rd_data_out (line_tx_out)
  );

  // code-group markers in 100M mode
  assign line_sos_out = m100 && line_tx_out.en && !ln_en_d;
  assign line_eos_out = m100 && !line_tx_out.en && ln_en_d;
  assign line_eop_out = eop;

  // ---------------- receive path ----------------
  ptl_pkg::ptl_nib_s rx_dly;               // line data after latency
  ptl_pkg::ptl_nib_s mac_rx, next_mac_rx;  // presented receive nibble
  logic [7:0]        crs_cnt, next_crs_cnt;// carrier delay counter
  logic              crs, next_crs;        // carrier sense level

  // one delay line serves receive data; the pointer is shared
  ptl_dly_mem #(.W(5), .AW(AW)) u_rx_dly (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .wr_addr_in  (wr_ptr),
    .wr_data_in  (line_q),
    .rd_addr_in  (rx_rd),
    .rd_data_out (rx_dly)
  );

  // carrier follows line activity after the on or off delay; a burst
  // shorter than the delay is filtered out entirely
  always_comb begin
    next_crs     = crs;
    next_crs_cnt = 8'h00;
    if (line_q.en != crs) begin
      next_crs_cnt = crs_cnt + 8'h01;
      if (line_q.en && crs_cnt == 8'(`PTL_CRS_ON_CYC - 1)) begin
        next_crs     = 1'b1;
        next_crs_cnt = 8'h00;
      end
      if (!line_q.en && crs_cnt == 8'(`PTL_CRS_OFF_CYC - 1)) begin
        next_crs     = 1'b0;
        next_crs_cnt = 8'h00;
      end
    end
    // the receive nibble changes only on the update edge
    next_mac_rx = mac_rx;
    if (rx_upd) begin
      next_mac_rx.en   = rx_dly.en;
      next_mac_rx.data = (mode == ptl_pkg::PTL_SER10) ?
                         {3'h0, rx_dly.data[0]} : rx_dly.data;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      crs     <= 1'b0;
      crs_cnt <= 8'h00;
      mac_rx  <= '0;
    end else begin
      crs     <= next_crs;
      crs_cnt <= next_crs_cnt;
      mac_rx  <= next_mac_rx;
    end
  end

  assign crs_out    = crs;
  assign mac_rx_out = mac_rx;

  // ---------------- checks ----------------
  logic [7:0] rx_ph;                  // length of current rx phase
  logic [7:0] eop_len;                // length of current eop level
  ptl_pkg::ptl_mode_e mode_d;         // mode last cycle, marks a switch
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_ph   <= 8'h01;
      eop_len <= 8'h00;
      mode_d  <= ptl_pkg::PTL_MII100;
    end else begin
      rx_ph   <= (rx_clk != next_rx_clk) ? 8'h01 : rx_ph + 8'h01;
      eop_len <= eop ? eop_len + 8'h01 : 8'h00;
      mode_d  <= mode;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  tx_sos_lat_a: assert property (
    m100 && $rose(tx_cap.en) |-> ##15 line_sos_out)
    else $error("start marker not 15 cycles after sample");
  tx_eos_lat_a: assert property (
    m100 && $fell(tx_cap.en) |-> ##15 line_eos_out)
    else $error("end marker not 15 cycles after sample");
  crs_on_lat_a: assert property (
    $rose(crs) |-> $past(line_q.en, 50) && line_q.en)
    else $error("carrier rose without 50 cycles of activity");
  rx_data_lat_a: assert property (
    $rose(rx_dly.en) |-> $past(line_q.en, 60) && !$past(line_q.en, 61))
    else $error("receive data not 60 cycles behind line");
  crs_off_lat_a: assert property (
    $fell(crs) |-> !$past(line_q.en, 60))
    else $error("carrier fell without 60 idle cycles");
  mii10_fall_a: assert property (
    mode == ptl_pkg::PTL_MII10 && tx_smp |=> $fell(tx_clk))
    else $error("10M MII sample not on falling edge");
  rx_phase_min_a: assert property (
    $changed(rx_clk) |-> $past(rx_ph) >= 8'h04)
    else $error("receive clock phase too short");
  tx10_lat_a: assert property (
    !m100 && $rose(tx_cap.en) |-> ##87 $rose(line_tx_out.en))
    else $error("10M line output not 87 cycles after sample");
  eop_hold_a: assert property (
    $fell(eop) |-> $past(eop_len) >= 8'(`PTL_EOP_MIN_CYC))
    else $error("end-of-packet level too short");
  // a mode switch cuts the running phase short, so drop such attempts
  ser_tx_high_a: assert property (
    disable iff (rst_in || mode != mode_d)
    mode == ptl_pkg::PTL_SER10 && $rose(tx_clk)
      |-> tx_clk[*6] ##1 !tx_clk)
    else $error("serial transmit clock high time wrong");
  ser_rx_upd_a: assert property (
    $past(mode) == ptl_pkg::PTL_SER10 && $changed(mac_rx) |-> $fell(rx_clk))
    else $error("serial receive data changed off falling edge");
  mii100_half_a: assert property (
    disable iff (rst_in || mode != mode_d)
    m100 && $rose(tx_clk) |-> tx_clk[*5] ##1 !tx_clk)
    else $error("100M transmit clock half period wrong");

  frame100_c: cover property (m100 ##0 line_sos_out);
  eop10_c:    cover property (!m100 && $fell(eop));
  crs_c:      cover property ($fell(crs));
  ser_rx_c:   cover property (mode == ptl_pkg::PTL_SER10 && rx_upd);

endmodule : ptl_timing

// File: tb/ptl_mac_model.sv
// mac-side partner model: drives transmit units on the transceiver tx clock
`timescale 1ns/1ps
module ptl_mac_model (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire logic [1:0]        mode_in,
  input  wire logic              tx_clk_in,
  input  wire logic              start_in,
  input  wire logic [7:0]        len_in,
  output ptl_pkg::ptl_nib_s      mac_tx_out,
  output logic                   busy_out
);
  logic       clk_q;   // tx clock as seen one cycle earlier
  logic [7:0] left;    // units still to send in this frame
  logic       launch;  // launch edge of the current mode

  // mii modes launch on the rising edge; serial launches on the falling
  // edge so the data is settled a whole low phase before the rising sample
  assign launch = (mode_in == 2'h2) ? (clk_q & ~tx_clk_in)
                                    : (~clk_q & tx_clk_in);

  // frame sequencer: one unit per launch edge, counting down to zero
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_q      <= 1'b0;
      left       <= 8'h00;
      mac_tx_out <= '0;
    end else begin
      clk_q <= tx_clk_in;
      if (launch && left != 8'h00) begin
        mac_tx_out.en   <= 1'b1;
        mac_tx_out.data <= left[3:0];
        left            <= left - 8'h01;
      end else if (launch) begin
        // released data flips so a stale nibble can never pass for fresh
        mac_tx_out.en   <= 1'b0;
        mac_tx_out.data <= ~mac_tx_out.data;
        if (start_in) begin
          left <= len_in;
        end
      end
    end
  end

  // busy while a frame is loaded or still on the wire
  assign busy_out = (left != 8'h00) | mac_tx_out.en;
endmodule : ptl_mac_model

// File: tb/tb.sv
// self-checking bench for the mac-side timing block
`timescale 1ns/1ps
module tb;
  localparam int CLK    = 4;   // system clock period in ns
  localparam int BIT100 = 10;  // ns per bit at 100 Mb/s
  localparam int BIT10  = 100; // ns per bit at 10 Mb/s
  localparam int SYNC   = 2;   // input synchroniser depth
  localparam int LIM    = 20000;

  logic              sys_clk_in;   // system clock
  logic              rst_in;       // async reset
  logic [1:0]        mode;         // interface mode
  logic              line_lock_in; // recovered or reference clocking
  logic              start;        // frame request to the mac model
  logic [7:0]        len;          // units per frame
  logic              tx_clk;       // generated clocks
  logic              rx_clk;
  logic              crs;          // carrier sense
  logic              sos;          // line markers
  logic              eos;
  logic              eop;
  logic              busy;
  ptl_pkg::ptl_nib_s mac_tx;       // mac transmit unit
  ptl_pkg::ptl_nib_s line_rx;      // line receive stream
  ptl_pkg::ptl_nib_s mac_rx;       // mac receive unit
  ptl_pkg::ptl_nib_s line_tx;      // line transmit stream
  int                n_fail = 0;
  int                cmp_count = 0;
  int                cyc = 0;

  ptl_timing i_ptl_timing (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .mode_in(mode), .mac_tx_in(mac_tx), .line_rx_in(line_rx),
    .line_lock_in(line_lock_in), .tx_clk_out(tx_clk), .rx_clk_out(rx_clk),
    .mac_rx_out(mac_rx), .crs_out(crs), .line_tx_out(line_tx),
    .line_sos_out(sos), .line_eos_out(eos), .line_eop_out(eop));

  ptl_mac_model i_ptl_mac_model (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .mode_in(mode), .tx_clk_in(tx_clk), .start_in(start), .len_in(len),
    .mac_tx_out(mac_tx), .busy_out(busy));

  // free-running system clock
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // cycle stamp and hang guard
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == LIM) begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  // one cycle on; outputs settled and inputs safe to change
  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask : tick

  // observed signal by index, so one wait loop serves them all
  function automatic logic sig(input int k);
    case (k)
      0: return tx_clk;
      1: return rx_clk;
      2: return crs;
      3: return line_tx.en;
      4: return mac_tx.en;
      5: return mac_rx.en;
      default: return eop;
    endcase
  endfunction : sig

  // bounded wait for a level; returns the stamp where it was seen
  task automatic wait_for(input int k, input logic v, output int t);
    int n;
    n = 0;
    while (sig(k) !== v && n < 2000) begin
      tick();
      n++;
    end
    if (n == 2000) begin
      check("wait bound", 0, 1);
    end
    t = cyc;
  endtask : wait_for

  // next tx capture edge: falling when fall is set, else rising
  task automatic edge_at(input logic fall, output int t);
    wait_for(0, fall, t);
    wait_for(0, ~fall, t);
  endtask : edge_at

  // mode changes are not glitch-free, so let the clocks settle first
  task automatic set_mode(input logic [1:0] m);
    mode = m;
    repeat (200) tick();
  endtask : set_mode

  // clock phase lengths in every mode, code 3 behaving as 100 Mb/s
  task automatic clocks_all();
    int t0, t1, t2;
    int exp_h [4] = '{20 / CLK, 200 / CLK, 25 / CLK, 20 / CLK};
    int exp_r [4] = '{20 / CLK, 200 / CLK, 50 / CLK, 20 / CLK};
    int exp_p [4] = '{40 / CLK, 400 / CLK, 100 / CLK, 40 / CLK};
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1:0]);
      for (int k = 0; k < 2; k++) begin
        wait_for(k, 1'b0, t0);
        wait_for(k, 1'b1, t0);
        wait_for(k, 1'b0, t1);
        wait_for(k, 1'b1, t2);
        check("clock high", k ? exp_r[m] : exp_h[m], t1 - t0);
        check("clock period", exp_p[m], t2 - t0);
      end
    end
  endtask : clocks_all

  // transmit latency from the capture edge, both ends of a frame
  task automatic tx_lat(input logic [1:0] m, input int lat, input logic fall);
    int t1, t2, t3;
    set_mode(m);
    start = 1'b1;
    wait_for(4, 1'b1, t1);
    start = 1'b0;
    edge_at(fall, t1);
    wait_for(3, 1'b1, t2);
    check("tx start latency", lat, t2 - t1);
    check("tx unit", m == 2'h2 ? len[0] : len[3:0], line_tx.data);
    check("start marker", m == 2'h0, sos);
    wait_for(4, 1'b0, t1);
    edge_at(fall, t1);
    wait_for(3, 1'b0, t2);
    check("tx end latency", lat, t2 - t1);
    check("end marker", m == 2'h0, eos);
    tick();
    check("eop level", m != 2'h0, eop);
    wait_for(6, 1'b0, t3);
    if (m != 2'h0) begin
      check("eop length", 300 / CLK, t3 - t2 - 1);
    end
    check("mac idle", 0, busy);
  endtask : tx_lat

  // carrier and data latency on the receive side
  task automatic rx_lat(input logic [1:0] m, input int per);
    int t0, t1;
    set_mode(m);
    line_rx = '{en: 1'b1, data: 4'hB};
    t0 = cyc;
    wait_for(2, 1'b1, t1);
    check("crs on", (20 * BIT100) / CLK + SYNC, t1 - t0);
    wait_for(5, 1'b1, t1);
    t1 = t1 - t0 - (24 * BIT100) / CLK - SYNC;
    check("rx data slot", 1, t1 >= 0 && t1 <= per);
    check("rx data", m == 2'h2 ? 4'h1 : 4'hB, mac_rx.data);
    check("rx update edge", m == 2'h0, rx_clk);
    line_rx = '{en: 1'b0, data: 4'h4};
    t0 = cyc;
    wait_for(2, 1'b0, t1);
    check("crs off", (24 * BIT100) / CLK + SYNC, t1 - t0);
  endtask : rx_lat

  // clock-source flips may stretch rx phases but never shorten them
  task automatic lock_stretch();
    int   run;
    logic last;
    set_mode(2'h0);
    run  = 5;
    last = rx_clk;
    for (int i = 0; i < 300; i++) begin
      tick();
      if (i % 7 == 0) begin
        line_lock_in = ~line_lock_in;
      end
      if (rx_clk !== last) begin
        check("rx phase floor", 1, run >= 20 / CLK);
        run = 0;
      end
      run++;
      last = rx_clk;
    end
  endtask : lock_stretch

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    rst_in       = 1'b1;
    mode         = 2'h0;
    line_rx      = '0;
    line_lock_in = 1'b0;
    start        = 1'b0;
    len          = 8'h09;
    repeat (4) tick();
    check("reset crs", 0, crs);
    rst_in = 1'b0;
    clocks_all();
    tx_lat(2'h0, (6 * BIT100) / CLK, 1'b0);
    tx_lat(2'h1, (35 * BIT10) / (10 * CLK), 1'b1);
    tx_lat(2'h2, (35 * BIT10) / (10 * CLK), 1'b0);
    rx_lat(2'h0, 20 * 2 / CLK);
    rx_lat(2'h2, 100 / CLK);
    lock_stretch();
    final_report();
  end
endmodule : tb
